/* File: design/dsp_dual_spi.sv */
// Functional notes
// - Two independent engines; second may be slave.
// - Sixteen-byte transmit and receive buffer each.
// - Each function's pad selected on its own.
// - First engine drives SCL/SDA, three MISO pads.
// - Master chip select on chosen GPIO pin.
// - Second master: 2 clock, 3 MOSI, 2 MISO.
// - Slave takes clock/MOSI/select, drives MISO.
// - Flash master has FIFOs before shift core.
`timescale 1ns/10ps
module dsp_dual_spi
  import dsp_pkg::*;
#(
  parameter int NGPIO = NUM_GPIO,
  parameter int DEPTH = BUF_DEPTH,
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Configuration
  input wire dsp_cfg_type [1:0] cfg,
  // Transmit byte streams
  input wire dsp_strm_type [1:0] txIn,
  output logic [1:0] txReady,
  // Receive byte streams
  output dsp_strm_type [1:0] rxOut,
  input wire logic [1:0] rxReady,
  // Status
  output logic [1:0] busy,
  output logic slaveOverrun,
  // Pads
  input wire logic [NUM_PADS-1:0] padIn,
  output logic [NUM_PADS-1:0] padOut,
  output logic [NUM_PADS-1:0] padOe,
  // Chip select GPIOs
  output logic [NGPIO-1:0] gpioCsOut,
  output logic [NGPIO-1:0] gpioCsOe
);
  localparam int LVL_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [NUM_PADS-1:0] sync1;
    logic [NUM_PADS-1:0] sync2;
    dsp_eng_type [1:0] eng;
    logic [NUM_PADS-1:0] padOut;
    logic [NUM_PADS-1:0] padOe;
    logic [NGPIO-1:0] gpioOut;
    logic [NGPIO-1:0] gpioOe;
    logic [1:0] busy;
    logic overrun;
  } dsp_top_type;

  dsp_top_type st_ff;
  dsp_top_type nxt_st;
  dsp_strm_type [1:0] txOut;
  logic [1:0] txPop;
  logic [1:0] rxPush;
  logic [1:0][BYTE_W-1:0] rxByte;
  logic [1:0] rxInReady;
  logic [1:0][LVL_W-1:0] rxLevel;

  for (genvar g = 0; g < 2; g++) begin : gBuf
    dsp_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(DEPTH),
      .LVL_W(LVL_W)
    ) uTx (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .inValid(txIn[g].valid),
      .inData(txIn[g].data),
      .inReady(txReady[g]),
      .outValid(txOut[g].valid),
      .outData(txOut[g].data),
      .outReady(txPop[g]),
      .level()
    );
    dsp_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(DEPTH),
      .LVL_W(LVL_W)
    ) uRx (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .inValid(rxPush[g]),
      .inData(rxByte[g]),
      .inReady(rxInReady[g]),
      .outValid(rxOut[g].valid),
      .outData(rxOut[g].data),
      .outReady(rxReady[g]),
      .level(rxLevel[g])
    );
  end

  always_comb begin
    dsp_eng_type e;
    dsp_eng_type ne;
    logic isSlave;
    logic misoIn;
    logic sckIn;
    logic mosiIn;
    logic csIn;
    logic canStart;
    logic canNext;
    e = '0;
    ne = '0;
    isSlave = 1'b0;
    misoIn = 1'b0;
    sckIn = 1'b0;
    mosiIn = 1'b0;
    csIn = 1'b0;
    canStart = 1'b0;
    canNext = 1'b0;
    nxt_st = st_ff;
    txPop = '0;
    rxPush = '0;
    rxByte = '0;
    nxt_st.sync1 = padIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.overrun = st_ff.overrun & cfg[1].en & cfg[1].slave;
    for (int i = 0; i < 2; i++) begin
      e = st_ff.eng[i];
      ne = e;
      isSlave = (i == 1) && cfg[i].slave;
      if (i == 0) begin
        unique case (cfg[i].misoSel)
          2'h1: misoIn = st_ff.sync2[PAD_P26];
          2'h2: misoIn = st_ff.sync2[PAD_P32];
          default: misoIn = st_ff.sync2[PAD_P24];
        endcase
      end else begin
        misoIn = cfg[i].misoSel[0] ? st_ff.sync2[PAD_P25] : st_ff.sync2[PAD_P1];
      end
      sckIn = cfg[i].clkSel ? st_ff.sync2[PAD_P24] : st_ff.sync2[PAD_P3];
      unique case (cfg[i].mosiSel)
        2'h1: mosiIn = st_ff.sync2[PAD_P27];
        2'h2: mosiIn = st_ff.sync2[PAD_P33];
        default: mosiIn = st_ff.sync2[PAD_P0];
      endcase
      unique case (cfg[i].csSel)
        2'h1: csIn = !st_ff.sync2[PAD_P26];
        2'h2: csIn = !st_ff.sync2[PAD_P32];
        default: csIn = !st_ff.sync2[PAD_P2];
      endcase
      canStart = cfg[i].en & txOut[i].valid & (rxLevel[i] < LVL_W'(DEPTH));
      canNext = cfg[i].en & txOut[i].valid & (rxLevel[i] < LVL_W'(DEPTH - 1));
      ne.prevSck = sckIn;
      ne.prevCs = csIn;
      if (isSlave) begin
        ne.st = ENG_IDLE;
        ne.sck = 1'b0;
        ne.div = '0;
        ne.csAct = csIn & cfg[i].en;
        if (!ne.csAct) begin
          ne.bitCnt = FIRST_BIT;
          ne.loadPend = 1'b0;
        end else if (!e.prevCs) begin
          txPop[i] = txOut[i].valid;
          ne.shTx = txOut[i].valid ? txOut[i].data : IDLE_FILL;
        end else if (sckIn && !e.prevSck) begin
          ne.shRx = {e.shRx[BYTE_W-2:0], mosiIn};
          if (e.bitCnt == LAST_BIT) begin
            rxPush[i] = 1'b1;
            rxByte[i] = ne.shRx;
            nxt_st.overrun = nxt_st.overrun | !rxInReady[i];
            ne.bitCnt = FIRST_BIT;
            ne.loadPend = 1'b1;
          end else begin
            ne.bitCnt = 3'(e.bitCnt + 1'b1);
          end
        end else if (!sckIn && e.prevSck) begin
          if (e.loadPend) begin
            txPop[i] = txOut[i].valid;
            ne.shTx = txOut[i].valid ? txOut[i].data : IDLE_FILL;
            ne.loadPend = 1'b0;
          end else begin
            ne.shTx = {e.shTx[BYTE_W-2:0], 1'b0};
          end
        end
      end else begin
        ne.loadPend = 1'b0;
        unique case (e.st)
          ENG_IDLE: begin
            ne.sck = 1'b0;
            ne.csAct = 1'b0;
            if (canStart) begin
              txPop[i] = 1'b1;
              ne.shTx = txOut[i].data;
              ne.mosi = txOut[i].data[BYTE_W-1];
              ne.csAct = 1'b1;
              ne.div = '0;
              ne.bitCnt = FIRST_BIT;
              ne.st = ENG_LOW;
            end
          end
          ENG_LOW: begin
            ne.div = DIV_W'(e.div + 1'b1);
            if (e.div == DIV_W'(SCK_HALF - 1)) begin
              ne.sck = 1'b1;
              ne.shRx = {e.shRx[BYTE_W-2:0], misoIn};
              ne.div = '0;
              ne.st = ENG_HIGH;
            end
          end
          ENG_HIGH: begin
            ne.div = DIV_W'(e.div + 1'b1);
            if (e.div == DIV_W'(SCK_HALF - 1)) begin
              ne.sck = 1'b0;
              ne.div = '0;
              if (e.bitCnt == LAST_BIT) begin
                rxPush[i] = 1'b1;
                rxByte[i] = e.shRx;
                if (canNext) begin
                  txPop[i] = 1'b1;
                  ne.shTx = txOut[i].data;
                  ne.mosi = txOut[i].data[BYTE_W-1];
                  ne.bitCnt = FIRST_BIT;
                  ne.st = ENG_LOW;
                end else begin
                  ne.csAct = 1'b0;
                  ne.st = ENG_IDLE;
                end
              end else begin
                ne.bitCnt = 3'(e.bitCnt + 1'b1);
                ne.shTx = {e.shTx[BYTE_W-2:0], 1'b0};
                ne.mosi = e.shTx[BYTE_W-2];
                ne.st = ENG_LOW;
              end
            end
          end
          default: begin
            ne.st = ENG_IDLE;
          end
        endcase
      end
      nxt_st.eng[i] = ne;
      nxt_st.busy[i] = ne.csAct;
    end
    nxt_st.padOut = '0;
    nxt_st.padOe = '0;
    nxt_st.gpioOut = '0;
    nxt_st.gpioOe = '0;
    if (cfg[0].en) begin
      // Clock and data on two-wire pads
      nxt_st.padOut[PAD_SCL] = nxt_st.eng[0].sck;
      nxt_st.padOe[PAD_SCL] = 1'b1;
      nxt_st.padOut[PAD_SDA] = nxt_st.eng[0].mosi;
      nxt_st.padOe[PAD_SDA] = 1'b1;
      if (32'(cfg[0].gpioSel) < NGPIO) begin
        nxt_st.gpioOut[cfg[0].gpioSel] = !nxt_st.eng[0].csAct;
        nxt_st.gpioOe[cfg[0].gpioSel] = 1'b1;
      end
    end
    if (cfg[1].en && cfg[1].slave) begin
      if (cfg[1].misoSel[0]) begin
        nxt_st.padOut[PAD_P25] = nxt_st.eng[1].shTx[BYTE_W-1];
        nxt_st.padOe[PAD_P25] = nxt_st.eng[1].csAct;
      end else begin
        nxt_st.padOut[PAD_P1] = nxt_st.eng[1].shTx[BYTE_W-1];
        nxt_st.padOe[PAD_P1] = nxt_st.eng[1].csAct;
      end
    end else if (cfg[1].en) begin
      if (cfg[1].clkSel) begin
        nxt_st.padOut[PAD_P24] = nxt_st.eng[1].sck;
        nxt_st.padOe[PAD_P24] = 1'b1;
      end else begin
        nxt_st.padOut[PAD_P3] = nxt_st.eng[1].sck;
        nxt_st.padOe[PAD_P3] = 1'b1;
      end
      unique case (cfg[1].mosiSel)
        2'h1: begin
          nxt_st.padOut[PAD_P4] = nxt_st.eng[1].mosi;
          nxt_st.padOe[PAD_P4] = 1'b1;
        end
        2'h2: begin
          nxt_st.padOut[PAD_P27] = nxt_st.eng[1].mosi;
          nxt_st.padOe[PAD_P27] = 1'b1;
        end
        default: begin
          nxt_st.padOut[PAD_P0] = nxt_st.eng[1].mosi;
          nxt_st.padOe[PAD_P0] = 1'b1;
        end
      endcase
      if (32'(cfg[1].gpioSel) < NGPIO) begin
        nxt_st.gpioOut[cfg[1].gpioSel] = !nxt_st.eng[1].csAct;
        nxt_st.gpioOe[cfg[1].gpioSel] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.sync1 <= '1;
      st_ff.sync2 <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign slaveOverrun = st_ff.overrun;
  assign padOut = st_ff.padOut;
  assign padOe = st_ff.padOe;
  assign gpioCsOut = st_ff.gpioOut;
  assign gpioCsOe = st_ff.gpioOe;

endmodule : dsp_dual_spi

/* File: design/dsp_pkg.sv */
package dsp_pkg;

  // Data and buffer sizes
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 16;
  localparam int NUM_GPIO = 14;
  localparam int GPIO_SEL_W = 4;

  // Serial clock timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYC = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 8;

  // Pad indices
  localparam int PAD_SCL = 0;
  localparam int PAD_SDA = 1;
  localparam int PAD_P0 = 2;
  localparam int PAD_P1 = 3;
  localparam int PAD_P2 = 4;
  localparam int PAD_P3 = 5;
  localparam int PAD_P4 = 6;
  localparam int PAD_P24 = 7;
  localparam int PAD_P25 = 8;
  localparam int PAD_P26 = 9;
  localparam int PAD_P27 = 10;
  localparam int PAD_P32 = 11;
  localparam int PAD_P33 = 12;
  localparam int NUM_PADS = 13;

  // Shift values
  localparam logic [BYTE_W-1:0] IDLE_FILL = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // Per-engine configuration
  typedef struct packed {
    logic en;
    logic slave;
    logic clkSel;
    logic [1:0] mosiSel;
    logic [1:0] misoSel;
    logic [1:0] csSel;
    logic [GPIO_SEL_W-1:0] gpioSel;
  } dsp_cfg_type;

  // Byte stream beat
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } dsp_strm_type;

  typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH} dsp_engst_type;

  // Engine state
  typedef struct packed {
    dsp_engst_type st;
    logic [DIV_W-1:0] div;
    logic [2:0] bitCnt;
    logic [BYTE_W-1:0] shTx;
    logic [BYTE_W-1:0] shRx;
    logic csAct;
    logic sck;
    logic mosi;
    logic prevSck;
    logic prevCs;
    logic loadPend;
  } dsp_eng_type;

endpackage : dsp_pkg

/* File: design/dsp_fifo.sv */
`timescale 1ns/10ps
module dsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  // Fill level
  output logic [LVL_W-1:0] level
);
  localparam int MD = DEPTH - 1;
  localparam int AW = (MD > 1) ? $clog2(MD) : 1;

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [LVL_W-1:0] cnt;
    logic oValid;
    logic [WIDTH-1:0] oData;
    logic iReady;
  } dsp_fifo_st_type;

  dsp_fifo_st_type st_ff;
  dsp_fifo_st_type nxt_st;
  logic [WIDTH-1:0] mem [MD];
  logic push;
  logic pop;
  logic take;

  always_comb begin
    nxt_st = st_ff;
    push = inValid & st_ff.iReady;
    pop = st_ff.oValid & outReady;
    take = (!st_ff.oValid | pop) & (st_ff.cnt != '0);
    if (take) begin
      nxt_st.oData = mem[st_ff.rd];
      nxt_st.oValid = 1'b1;
      nxt_st.rd = (st_ff.rd == AW'(MD - 1)) ? '0 : AW'(st_ff.rd + 1'b1);
    end else if (pop) begin
      nxt_st.oValid = 1'b0;
    end
    if (push) begin
      nxt_st.wr = (st_ff.wr == AW'(MD - 1)) ? '0 : AW'(st_ff.wr + 1'b1);
    end
    nxt_st.cnt = LVL_W'(st_ff.cnt + LVL_W'(push) - LVL_W'(take));
    nxt_st.iReady = (nxt_st.cnt < LVL_W'(MD));
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_ff.wr] <= inData;
    end
  end

  assign inReady = st_ff.iReady;
  assign outValid = st_ff.oValid;
  assign outData = st_ff.oData;
  assign level = LVL_W'(st_ff.cnt + LVL_W'(st_ff.oValid));

endmodule : dsp_fifo

/* File: testbench/dsp_dual_spi_asserts.sv */
`timescale 1ns/10ps
module dsp_dual_spi_asserts
  import dsp_pkg::*;
#(
  parameter int NGPIO = NUM_GPIO,
  parameter int DEPTH = BUF_DEPTH,
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Watched ports
  input wire dsp_cfg_type [1:0] cfg,
  input wire logic [1:0] busy,
  input wire logic [NUM_PADS-1:0] padIn,
  input wire logic [NUM_PADS-1:0] padOut,
  input wire logic [NUM_PADS-1:0] padOe,
  input wire logic [NGPIO-1:0] gpioCsOut,
  input wire logic [NGPIO-1:0] gpioCsOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic sck0;
  logic slv1;
  logic sckPrev_ff;
  logic [7:0] runLen_ff;
  logic [7:0] riseCnt_ff;
  assign sck0 = padOut[PAD_SCL];
  assign slv1 = cfg[1].en && cfg[1].slave && cfg[1].misoSel == 2'h0 && cfg[1].csSel == 2'h0;
  // Length of the present clock level and rises under select
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sckPrev_ff <= 1'b0;
      runLen_ff <= 8'h00;
      riseCnt_ff <= 8'h00;
    end else begin
      sckPrev_ff <= sck0;
      runLen_ff <= (sck0 != sckPrev_ff) ? 8'h01 : runLen_ff + 8'h01;
      riseCnt_ff <= !busy[0] ? 8'h00 : riseCnt_ff + {7'h00, sck0 && !sckPrev_ff};
    end
  end
  sequence s_selDrop;
    slv1 ##0 $fell(padIn[PAD_P2]);
  endsequence
  sequence s_selSeen;
    ##[1:6] busy[1];
  endsequence
  sequence s_slvOn;
    (slv1 && busy[1])[*3];
  endsequence
  property p_sckIdle;
    cfg[0].en && !busy[0] && !$past(busy[0]) |-> !sck0;
  endproperty
  property p_csLevel;
    busy[0] && cfg[0].en && !cfg[1].en |-> gpioCsOe[cfg[0].gpioSel] && !gpioCsOut[cfg[0].gpioSel];
  endproperty
  property p_byteBits;
    $fell(busy[0]) |-> riseCnt_ff[2:0] == 3'h0 && riseCnt_ff != 8'h00;
  endproperty
  property p_sckHigh;
    busy[0] && $fell(sck0) |-> runLen_ff == SCK_HALF;
  endproperty
  property p_mosiHold;
    busy[0] && sck0 && $past(sck0) |-> $stable(padOut[PAD_SDA]);
  endproperty
  property p_padDrive;
    busy[0] && cfg[0].en |-> padOe[PAD_SCL] && padOe[PAD_SDA];
  endproperty
  property p_slvSel;
    s_selDrop |-> s_selSeen;
  endproperty
  property p_slvOe;
    s_slvOn |-> padOe[PAD_P1];
  endproperty
  a_sckIdle: assert property (p_sckIdle) else $error("clock not idle low");
  a_csLevel: assert property (p_csLevel) else $error("select not low");
  a_byteBits: assert property (p_byteBits) else $error("partial byte");
  a_sckHigh: assert property (p_sckHigh) else $error("clock high phase length");
  a_mosiHold: assert property (p_mosiHold) else $error("data moved while clock high");
  a_padDrive: assert property (p_padDrive) else $error("pads not driven");
  a_slvSel: assert property (p_slvSel) else $error("select not seen");
  a_slvOe: assert property (p_slvOe) else $error("slave data not driven");
endmodule : dsp_dual_spi_asserts

/* File: testbench/dsp_flash_model.sv */
`timescale 1ns/10ps
module dsp_flash_model (
  // Serial link
  input wire logic sck,
  input wire logic mosi,
  input wire logic csN,
  output logic miso
);
  logic [7:0] shOut = 8'ha5;
  logic [7:0] shIn = 8'ha5;
  logic [2:0] bitCnt = 3'h0;
  logic lastBit = 1'b0;
  always @(posedge sck) begin
    if (!csN) begin
      shIn = {shIn[6:0], mosi};
      bitCnt = bitCnt + 3'h1;
    end
  end
  always @(negedge sck or posedge csN) begin
    if (bitCnt == 3'h0) begin
      shOut = shIn;
    end else if (!csN) begin
      shOut = {shOut[6:0], 1'b0};
    end
  end
  always @(csN or shOut) begin
    if (!csN) begin
      lastBit = shOut[7];
    end
  end
  // Released line shows the inverse
  assign miso = csN ? ~lastBit : shOut[7];
endmodule : dsp_flash_model

/* File: testbench/dsp_dual_spi_tb.sv */
`timescale 1ns/10ps
module dsp_dual_spi_tb
  import dsp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  dsp_cfg_type [1:0] cfg = '0;
  dsp_strm_type [1:0] txIn = '0;
  dsp_strm_type [1:0] rxOut;
  logic [1:0] rxReady = 2'h0;
  logic [1:0] txReady;
  logic [1:0] busy;
  logic [NUM_PADS-1:0] padIn;
  logic [NUM_PADS-1:0] padOut;
  logic [NUM_PADS-1:0] padOe;
  logic [NUM_GPIO-1:0] csOut;
  logic [NUM_GPIO-1:0] csOe;
  int sckPad = PAD_SCL;
  int mosiPad = PAD_SDA;
  int misoPad = PAD_P24;
  int csIdx = 3;
  logic sSck = 1'b0;
  logic sMosi = 1'b0;
  logic sCsN = 1'b1;
  int sClkPad = PAD_P3;
  int sMosiPad = PAD_P0;
  int sCsPad = PAD_P2;
  logic ovr;
  logic pSck;
  logic pCsN;
  logic pMiso;
  logic [7:0] echoB = 8'ha5;
  int n_mismatch = 0;
  int cmp_count = 0;
  assign pSck = padOe[sckPad] & padOut[sckPad];
  assign pCsN = csOe[csIdx] ? csOut[csIdx] : 1'b1;
  always_comb begin
    padIn = '1;
    padIn[misoPad] = pMiso;
    padIn[sClkPad] = sSck;
    padIn[sMosiPad] = sMosi;
    padIn[sCsPad] = sCsN;
  end
  dsp_dual_spi #(.SCK_HALF(16)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .txIn(txIn), .txReady(txReady), .rxOut(rxOut),
    .rxReady(rxReady), .busy(busy), .slaveOverrun(ovr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .gpioCsOut(csOut), .gpioCsOe(csOe));
  dsp_flash_model flash (.sck(pSck), .mosi(padOut[mosiPad]), .csN(pCsN), .miso(pMiso));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic push_n(input int e, input logic [7:0] d0, input int n);
    for (int k = 0; k < n; k++) begin
      txIn[e] <= {1'b1, d0 + 8'(k)};
      do @(posedge sys_clk); while (txReady[e] !== 1'b1);
    end
    txIn[e] <= '0;
  endtask : push_n
  task automatic pop(input int e, input logic [7:0] exp);
    int w = 0;
    rxReady[e] <= 1'b1;
    do begin
      @(posedge sys_clk);
      w++;
    end while (rxOut[e].valid !== 1'b1 && w < 2000);
    chk({7'h00, rxOut[e].valid}, 8'h01);
    chk(rxOut[e].data, exp);
    rxReady[e] <= 1'b0;
    @(posedge sys_clk);
  endtask : pop
  task automatic xfer(input int e, input logic [7:0] d0, input int n);
    push_n(e, d0, n);
    for (int k = 0; k < n; k++) begin
      pop(e, echoB);
      echoB = d0 + 8'(k);
    end
  endtask : xfer
  task automatic t_m1();
    int ck[2] = '{PAD_P3, PAD_P24};
    int mo[3] = '{PAD_P0, PAD_P4, PAD_P27};
    int mi[2] = '{PAD_P1, PAD_P25};
    csIdx = 5;
    for (int i = 0; i < 3; i++) begin
      sckPad = ck[i % 2];
      mosiPad = mo[i];
      misoPad = mi[i % 2];
      cfg[1] <= '{1'b1, 1'b0, 1'(i % 2), 2'(i), 2'(i % 2), 2'h0, 4'h5};
      @(posedge sys_clk);
      xfer(1, 8'h81 + 8'(i), 2);
    end
    cfg[1] <= '0;
    @(posedge sys_clk);
  endtask : t_m1
  task automatic t_m0();
    int mi[3] = '{PAD_P24, PAD_P26, PAD_P32};
    sckPad = PAD_SCL;
    mosiPad = PAD_SDA;
    csIdx = 3;
    for (int m = 0; m < 3; m++) begin
      misoPad = mi[m];
      cfg[0] <= '{1'b1, 1'b0, 1'b0, 2'h0, 2'(m), 2'h0, 4'h3};
      @(posedge sys_clk);
      xfer(0, 8'h30 + 8'(m * 16), 2);
    end
  endtask : t_m0
  task automatic t_fill();
    misoPad = PAD_P24;
    cfg[0] <= '{1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 4'h3};
    push_n(0, 8'hc0, BUF_DEPTH);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, txReady[0]}, 8'h00);
    cfg[0].en <= 1'b1;
    repeat (4600) @(posedge sys_clk);
    chk({7'h00, busy[0]}, 8'h00);
    for (int k = 0; k < BUF_DEPTH; k++) begin
      pop(0, echoB);
      echoB = 8'hc0 + 8'(k);
    end
    cfg[0] <= '0;
    @(posedge sys_clk);
  endtask : t_fill
  task automatic sxfer(input logic [7:0] d, input logic [7:0] exp, input int mp);
    logic [7:0] q;
    sCsN <= 1'b0;
    repeat (16) @(posedge sys_clk);
    for (int b = 7; b >= 0; b--) begin
      sMosi <= d[b];
      repeat (16) @(posedge sys_clk);
      sSck <= 1'b1;
      q[b] = padOe[mp] ? padOut[mp] : ~exp[b];
      repeat (16) @(posedge sys_clk);
      sSck <= 1'b0;
    end
    repeat (16) @(posedge sys_clk);
    sCsN <= 1'b1;
    repeat (16) @(posedge sys_clk);
    chk(q, exp);
  endtask : sxfer
  task automatic t_slave();
    int ckp[2] = '{PAD_P3, PAD_P24};
    int mop[3] = '{PAD_P0, PAD_P27, PAD_P33};
    int csp[3] = '{PAD_P2, PAD_P26, PAD_P32};
    int mip[2] = '{PAD_P1, PAD_P25};
    misoPad = PAD_P1;
    cfg[1] <= '{1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0, 4'h0};
    push_n(1, 8'h96, 1);
    repeat (4) @(posedge sys_clk);
    sxfer(8'h3c, 8'h96, PAD_P1);
    pop(1, 8'h3c);
    chk({7'h00, ovr}, 8'h00);
    for (int k = 0; k < 17; k++) begin
      sClkPad = ckp[k % 2];
      sMosiPad = mop[k % 3];
      sCsPad = csp[k % 3];
      cfg[1] <= '{1'b1, 1'b1, 1'(k % 2), 2'(k % 3), 2'(k % 2), 2'(k % 3), 4'h0};
      @(posedge sys_clk);
      sxfer(8'h10 + 8'(k), 8'h00, mip[k % 2]);
    end
    chk({7'h00, ovr}, 8'h01);
    cfg[1].en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({7'h00, ovr}, 8'h00);
    for (int k = 0; k < BUF_DEPTH; k++) begin
      pop(1, 8'h10 + 8'(k));
    end
  endtask : t_slave
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_m1();
    t_m0();
    t_fill();
    t_slave();
    close_out();
  end
endmodule : dsp_dual_spi_tb

bind dsp_dual_spi dsp_dual_spi_asserts #(.NGPIO(NGPIO), .DEPTH(DEPTH), .SCK_HALF(SCK_HALF)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .busy(busy), .padIn(padIn), .padOut(padOut),
  .padOe(padOe), .gpioCsOut(gpioCsOut), .gpioCsOe(gpioCsOe));
